//--- src/data_pointer_address_unit.sv
`timescale 1ns/1ns
module data_pointer_address_unit (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // register port: addr = {module, subindex}
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  output logic             reg_hit,
  // indirect memory access from the decoder
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [1:0]  mem_ptr,
  input  wire logic [1:0]  mem_op,
  input  wire logic        code_fetch_hit,
  // shared data memory port
  output logic [16:0]      dmem_addr,
  output logic             dmem_word,
  output logic             dmem_rd,
  output logic             dmem_wr,
  // pointer state
  output logic [1:0]       source_pointer_select,
  output logic             source_valid
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [16:0] first_data_pointer_q;
  logic [16:0] second_data_pointer_q;
  logic [16:0] frame_base_register_q;
  logic [8:0]  frame_offset_q;
  logic [2:0]  wbs_q;           // frame, second, first
  logic [1:0]  sel_q;
  logic        valid_q;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  function automatic logic is_reg(input logic [7:0] a, input logic [3:0] m, input logic [3:0] i);
    is_reg = (a[7:4] == m) && (a[3:0] == i);
  endfunction

  // widen an external 16-bit value into the mode field of a stored pointer
  function automatic logic [16:0] load16(input logic [16:0] old, input logic [15:0] v, input logic wm);
    load16 = wm ? {v, old[0]} : {old[16], v};
  endfunction

  logic wr_first, wr_second, wr_base, wr_ofs, wr_ctrl, wr_discard;
  logic rd_known;

  always_comb begin
    wr_first   = reg_wr && is_reg(reg_addr, dptr_pkg::MOD_DPTR, dptr_pkg::IDX_FIRST);
    wr_second  = reg_wr && is_reg(reg_addr, dptr_pkg::MOD_DPTR, dptr_pkg::IDX_SECOND);
    wr_base    = reg_wr && is_reg(reg_addr, dptr_pkg::MOD_PTRCTL, dptr_pkg::IDX_BASE);
    wr_ofs     = reg_wr && is_reg(reg_addr, dptr_pkg::MOD_PTRCTL, dptr_pkg::IDX_OFFSET);
    wr_ctrl    = reg_wr && is_reg(reg_addr, dptr_pkg::MOD_PTRCTL, dptr_pkg::IDX_CTRL);
    wr_discard = reg_wr && is_reg(reg_addr, dptr_pkg::MOD_DISCARD, dptr_pkg::IDX_DISCARD);
    rd_known   = is_reg(reg_addr, dptr_pkg::MOD_DPTR, dptr_pkg::IDX_FIRST)
              || is_reg(reg_addr, dptr_pkg::MOD_DPTR, dptr_pkg::IDX_SECOND)
              || is_reg(reg_addr, dptr_pkg::MOD_PTRCTL, dptr_pkg::IDX_BASE)
              || is_reg(reg_addr, dptr_pkg::MOD_PTRCTL, dptr_pkg::IDX_OFFSET)
              || is_reg(reg_addr, dptr_pkg::MOD_PTRCTL, dptr_pkg::IDX_CTRL)
              || is_reg(reg_addr, dptr_pkg::MOD_PTRCTL, dptr_pkg::IDX_FRAME);
  end

  // ------------------------------------------------------------
  // field stepping and views, one instance per pointer register; the frame base one only gives its view
  // ------------------------------------------------------------
  logic [1:0]  op_first, op_second, op_frame;
  logic [16:0] step_first, step_second;
  logic [8:0]  step_ofs;
  logic [15:0] view_first, view_second, view_base;
  logic [7:0]  view_ofs;
  logic        mem_any;
  logic [1:0]  acc_ptr;

  // reads go through the active source pointer, writes through the one they name;
  // only that pointer steps, the frame base has none
  always_comb begin
    mem_any   = mem_rd || mem_wr;
    acc_ptr   = mem_wr ? mem_ptr : (sel_q[1] ? dptr_pkg::PTR_FRAME : sel_q);
    op_first  = (mem_any && acc_ptr == dptr_pkg::PTR_FIRST)  ? mem_op : dptr_pkg::MOD_NONE;
    op_second = (mem_any && acc_ptr == dptr_pkg::PTR_SECOND) ? mem_op : dptr_pkg::MOD_NONE;
    op_frame  = (mem_any && acc_ptr == dptr_pkg::PTR_FRAME)  ? mem_op : dptr_pkg::MOD_NONE;
  end

  ptr_field_step #(.W(16)) u_step_first (
    .ptr       (first_data_pointer_q),
    .word_mode (wbs_q[0]),
    .op        (op_first),
    .stepped   (step_first),
    .view      (view_first)
  );

  ptr_field_step #(.W(16)) u_step_second (
    .ptr       (second_data_pointer_q),
    .word_mode (wbs_q[1]),
    .op        (op_second),
    .stepped   (step_second),
    .view      (view_second)
  );

  ptr_field_step #(.W(8)) u_step_ofs (
    .ptr       (frame_offset_q),
    .word_mode (wbs_q[2]),
    .op        (op_frame),
    .stepped   (step_ofs),
    .view      (view_ofs)
  );

  ptr_field_step #(.W(16)) u_view_base (
    .ptr       (frame_base_register_q),
    .word_mode (wbs_q[2]),
    .op        (dptr_pkg::MOD_NONE),
    .stepped   (),
    .view      (view_base)
  );

  // ------------------------------------------------------------
  // pointer registers
  // ------------------------------------------------------------
  // register writes load the mode field; spare bit kept, so mode swaps alter no stored bit but change the field that reads see
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      first_data_pointer_q  <= dptr_pkg::PTR_RESET;
      second_data_pointer_q <= dptr_pkg::PTR_RESET;
      frame_base_register_q <= dptr_pkg::PTR_RESET;
      frame_offset_q        <= dptr_pkg::OFS_RESET;
    end else begin
      if (wr_first) begin
        first_data_pointer_q <= load16(first_data_pointer_q, reg_wdata, wbs_q[0]);
      end else begin
        first_data_pointer_q <= step_first;
      end
      if (wr_second) begin
        second_data_pointer_q <= load16(second_data_pointer_q, reg_wdata, wbs_q[1]);
      end else begin
        second_data_pointer_q <= step_second;
      end
      if (wr_base) begin
        frame_base_register_q <= load16(frame_base_register_q, reg_wdata, wbs_q[2]);
      end
      if (wr_ofs) begin
        frame_offset_q <= wbs_q[2] ? {reg_wdata[7:0], frame_offset_q[0]}
                                   : {frame_offset_q[8], reg_wdata[7:0]};
      end else begin
        frame_offset_q <= step_ofs;
      end
    end
  end

  // ------------------------------------------------------------
  // mode bits and active source selection
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wbs_q <= dptr_pkg::CTRL_RESET[dptr_pkg::WBS_FRAME:dptr_pkg::WBS_FIRST];
    end else if (wr_ctrl) begin
      wbs_q <= reg_wdata[dptr_pkg::WBS_FRAME:dptr_pkg::WBS_FIRST];
    end
  end

  // later lines win: a memory write in the same cycle as a register write takes over
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sel_q <= dptr_pkg::CTRL_RESET[dptr_pkg::SEL_MSB:dptr_pkg::SEL_LSB];
    end else begin
      if (wr_ctrl) begin
        sel_q <= reg_wdata[dptr_pkg::SEL_MSB:dptr_pkg::SEL_LSB];
      end
      if (wr_first) begin
        sel_q <= dptr_pkg::SEL_FIRST;
      end
      if (wr_second) begin
        sel_q <= dptr_pkg::SEL_SECOND;
      end
      if (wr_base || wr_ofs) begin
        sel_q <= dptr_pkg::SEL_FRAME;
      end
      if (mem_wr) begin
        sel_q <= mem_ptr;
      end
    end
  end

  // a code fetch from the selected memory drops the selection until reselected
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      valid_q <= 1'b1;
    end else if (wr_ctrl || wr_first || wr_second || wr_base || wr_ofs || mem_wr) begin
      valid_q <= 1'b1;
    end else if (code_fetch_hit) begin
      valid_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // shared memory port
  // ------------------------------------------------------------
  logic [16:0] old_addr;
  logic [16:0] new_addr;
  logic        acc_word;
  logic [16:0] frame_sum;

  // frame address is base plus the offset field, scaled into the same layout
  function automatic logic [16:0] frame_addr(input logic [16:0] b, input logic [8:0] o, input logic wm);
    frame_addr = wm ? {(b[16:1] + {8'h00, o[8:1]}), b[0]} : {b[16], (b[15:0] + {8'h00, o[7:0]})};
  endfunction

  always_comb begin
    unique case (acc_ptr)
      dptr_pkg::PTR_SECOND: begin
        old_addr = second_data_pointer_q;
        new_addr = step_second;
        acc_word = wbs_q[1];
      end
      dptr_pkg::PTR_FRAME: begin
        old_addr = frame_addr(frame_base_register_q, frame_offset_q, wbs_q[2]);
        new_addr = frame_addr(frame_base_register_q, step_ofs, wbs_q[2]);
        acc_word = wbs_q[2];
      end
      default: begin
        old_addr = first_data_pointer_q;
        new_addr = step_first;
        acc_word = wbs_q[0];
      end
    endcase
    frame_sum = frame_addr(frame_base_register_q, frame_offset_q, wbs_q[2]);
  end

  // writes use the stepped address, reads the address before the step
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dmem_addr <= dptr_pkg::PTR_RESET;
      dmem_word <= 1'b0;
      dmem_rd   <= 1'b0;
      dmem_wr   <= 1'b0;
    end else begin
      dmem_rd <= mem_rd && !mem_wr;
      dmem_wr <= mem_wr;
      if (mem_wr) begin
        dmem_addr <= new_addr;
        dmem_word <= acc_word;
      end else if (mem_rd) begin
        dmem_addr <= old_addr;
        dmem_word <= acc_word;
      end
    end
  end

  // ------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------
  logic [15:0] rd_val;

  always_comb begin
    rd_val = 16'h0000;
    if (is_reg(reg_addr, dptr_pkg::MOD_DPTR, dptr_pkg::IDX_FIRST)) begin
      rd_val = view_first;
    end else if (is_reg(reg_addr, dptr_pkg::MOD_DPTR, dptr_pkg::IDX_SECOND)) begin
      rd_val = view_second;
    end else if (is_reg(reg_addr, dptr_pkg::MOD_PTRCTL, dptr_pkg::IDX_BASE)) begin
      rd_val = view_base;
    end else if (is_reg(reg_addr, dptr_pkg::MOD_PTRCTL, dptr_pkg::IDX_OFFSET)) begin
      rd_val = {8'h00, view_ofs};
    end else if (is_reg(reg_addr, dptr_pkg::MOD_PTRCTL, dptr_pkg::IDX_CTRL)) begin
      rd_val = {11'h000, wbs_q, sel_q};
    end else if (is_reg(reg_addr, dptr_pkg::MOD_PTRCTL, dptr_pkg::IDX_FRAME)) begin
      rd_val = wbs_q[2] ? frame_sum[16:1] : frame_sum[15:0];
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
      reg_hit   <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_val : 16'h0000;
      reg_hit   <= reg_rd && rd_known;
    end
  end

  // ------------------------------------------------------------
  // state outputs
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      source_pointer_select <= dptr_pkg::CTRL_RESET[dptr_pkg::SEL_MSB:dptr_pkg::SEL_LSB];
      source_valid          <= 1'b1;
    end else begin
      source_pointer_select <= sel_q;
      source_valid          <= valid_q;
    end
  end

  // wr_discard is decoded only so the write is recognised and swallowed
  logic discard_seen;
  assign discard_seen = wr_discard;

endmodule

//--- src/dptr_pkg.sv
package dptr_pkg;

  // ------------------------------------------------------------
  // register addressing (module specifier, subindex)
  // ------------------------------------------------------------
  localparam logic [3:0] MOD_PTRCTL   = 4'hE;   // pointer control module
  localparam logic [3:0] MOD_DPTR     = 4'hF;   // data pointer module
  localparam logic [3:0] MOD_DISCARD  = 4'h6;   // discard destination module
  localparam logic [3:0] IDX_OFFSET   = 4'h3;   // in MOD_PTRCTL
  localparam logic [3:0] IDX_CTRL     = 4'h4;   // in MOD_PTRCTL
  localparam logic [3:0] IDX_BASE     = 4'h7;   // in MOD_PTRCTL
  localparam logic [3:0] IDX_FRAME    = 4'hB;   // in MOD_PTRCTL, read only
  localparam logic [3:0] IDX_FIRST    = 4'h3;   // in MOD_DPTR
  localparam logic [3:0] IDX_SECOND   = 4'h7;   // in MOD_DPTR
  localparam logic [3:0] IDX_DISCARD  = 4'h7;   // in MOD_DISCARD

  // ------------------------------------------------------------
  // control register fields and reset values
  // ------------------------------------------------------------
  localparam int         SEL_LSB      = 0;
  localparam int         SEL_MSB      = 1;
  localparam int         WBS_FIRST    = 2;
  localparam int         WBS_SECOND   = 3;
  localparam int         WBS_FRAME    = 4;
  localparam logic [1:0] SEL_FIRST    = 2'h0;
  localparam logic [1:0] SEL_SECOND   = 2'h1;
  localparam logic [1:0] SEL_FRAME    = 2'h2;
  localparam logic [4:0] CTRL_RESET   = 5'h00;
  localparam logic [16:0] PTR_RESET   = 17'h00000;
  localparam logic [8:0] OFS_RESET    = 9'h000;

  // ------------------------------------------------------------
  // pointer access operations and source selection
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MOD_NONE = 2'h0,
    MOD_INC  = 2'h1,
    MOD_DEC  = 2'h2
  } modify_e;

  typedef enum logic [1:0] {
    PTR_FIRST  = 2'h0,
    PTR_SECOND = 2'h1,
    PTR_FRAME  = 2'h2
  } ptr_e;

endpackage

//--- src/ptr_field_step.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// field-limited pointer step and field view
// ------------------------------------------------------------
// works on a pointer of W+1 internal bits; word mode uses [W:1], byte [W-1:0]
module ptr_field_step #(
  parameter int W = 16
) (
  // pointer and mode
  input  wire logic [W:0]   ptr,
  input  wire logic         word_mode,
  input  wire logic [1:0]   op,
  // results
  output logic [W:0]        stepped,
  output logic [W-1:0]      view
);

  logic [W-1:0] field;
  logic [W-1:0] next_field;

  // the field alone wraps, the spare bit never takes a carry
  always_comb begin
    field = word_mode ? ptr[W:1] : ptr[W-1:0];
    unique case (op)
      dptr_pkg::MOD_INC: next_field = field + 1'b1;
      dptr_pkg::MOD_DEC: next_field = field - 1'b1;
      default:           next_field = field;
    endcase
    stepped = word_mode ? {next_field, ptr[0]} : {ptr[W], next_field};
    view    = field;
  end

endmodule

//--- testbench/data_pointer_address_unit_asserts.sv
`timescale 1ns/1ns
module dptr_unit_checker (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_hit,
  // indirect access
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic [1:0]  mem_ptr,
  input wire logic [1:0]  mem_op,
  input wire logic        code_fetch_hit,
  // memory port and state
  input wire logic [16:0] dmem_addr,
  input wire logic        dmem_word,
  input wire logic        dmem_rd,
  input wire logic        dmem_wr,
  input wire logic [1:0]  source_pointer_select,
  input wire logic        source_valid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // a memory write is taken, the select output follows two edges on
  sequence write_taken;
    mem_wr;
  endsequence
  sequence select_lands;
    ##2 source_pointer_select == $past(mem_ptr, 2);
  endsequence

  write_sel_a: assert property (write_taken |-> select_lands) else $error("select misses write pointer");
  first_sel_a: assert property (
    reg_wr && reg_addr == 8'hF3 && !mem_wr |-> ##2 source_pointer_select == 2'h0)
    else $error("first pointer write not selected");
  ofs_sel_a: assert property (
    reg_wr && reg_addr == 8'hE3 && !mem_wr |-> ##2 source_pointer_select[1])
    else $error("offset write not selecting frame");
  ctrl_sel_a: assert property (
    reg_wr && reg_addr == 8'hE4 && !mem_wr |-> ##2 source_pointer_select == $past(reg_wdata[1:0], 2))
    else $error("control select field lost");
  wr_strobe_a: assert property (mem_wr |=> dmem_wr && !dmem_rd) else $error("write strobe missing");
  rd_strobe_a: assert property (mem_rd && !mem_wr |=> dmem_rd && !dmem_wr) else $error("read strobe missing");
  idle_port_a: assert property (
    !mem_rd && !mem_wr |=> !dmem_rd && !dmem_wr && $stable(dmem_addr))
    else $error("memory port moved while idle");
  map_hit_a: assert property (
    reg_rd && reg_addr inside {8'hF3, 8'hF7, 8'hE7, 8'hE3, 8'hE4, 8'hEB} |=> reg_hit)
    else $error("mapped read not hit");
  discard_read_a: assert property (
    reg_rd && reg_addr == 8'h67 |=> !reg_hit && reg_rdata == 16'h0000)
    else $error("discard place readable");
  fetch_drop_a: assert property (
    code_fetch_hit && !mem_wr && !reg_wr |-> ##[1:2] !source_valid)
    else $error("fetch did not drop selection");
endmodule

bind data_pointer_address_unit dptr_unit_checker chk (
  .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .mem_rd(mem_rd), .mem_wr(mem_wr),
  .mem_ptr(mem_ptr), .mem_op(mem_op), .code_fetch_hit(code_fetch_hit), .dmem_addr(dmem_addr),
  .dmem_word(dmem_word), .dmem_rd(dmem_rd), .dmem_wr(dmem_wr),
  .source_pointer_select(source_pointer_select), .source_valid(source_valid)
);

//--- testbench/dptr_core_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// core decoder stand-in: indirect accesses and fetch notices
// ------------------------------------------------------------
module dptr_core_model (
  // clock
  input  wire logic ref_clk,
  // indirect access requests
  output logic      mem_rd,
  output logic      mem_wr,
  output logic [1:0] mem_ptr,
  output logic [1:0] mem_op,
  // code fetch notice
  output logic      code_fetch_hit
);
  initial begin
    mem_rd         = 1'b0;
    mem_wr         = 1'b0;
    mem_ptr        = 2'h3;
    mem_op         = 2'h3;
    code_fetch_hit = 1'b0;
  end

  // one instruction reads or writes, never both through one stepped pointer
  task automatic access(input logic rd, input logic [1:0] ptr, input logic [1:0] op);
    @(posedge ref_clk);
    mem_rd  <= rd;
    mem_wr  <= ~rd;
    mem_ptr <= ptr;
    mem_op  <= op;
    @(posedge ref_clk);
    mem_rd  <= 1'b0;
    mem_wr  <= 1'b0;
    mem_ptr <= ~ptr;  // idle qualifiers show junk, not the last value
    mem_op  <= ~op;
    #1;
  endtask

  // code fetch enabled from the memory of the active pointer
  task automatic fetch();
    @(posedge ref_clk);
    code_fetch_hit <= 1'b1;
    @(posedge ref_clk);
    code_fetch_hit <= 1'b0;
  endtask
endmodule

//--- testbench/tb_data_pointer_address_unit.sv
`timescale 1ns/1ns
module tb_data_pointer_address_unit;
  // ------------------------------------------------------------
  // signals and cases
  // ------------------------------------------------------------
  typedef struct {
    logic [4:0] ctrl; logic [1:0] ptr; logic [1:0] op; logic rd;
    logic [15:0] pre; logic [7:0] ofs; logic [16:0] addr; logic [15:0] back;
  } row_s;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic        reg_hit;
  logic        mem_rd;
  logic        mem_wr;
  logic [1:0]  mem_ptr;
  logic [1:0]  mem_op;
  logic        code_fetch_hit;
  logic [16:0] dmem_addr;
  logic        dmem_word;
  logic        dmem_rd;
  logic        dmem_wr;
  logic [1:0]  source_pointer_select;
  logic        source_valid;
  logic [15:0] v;
  logic        h;
  logic        w;
  int          n_mismatch = 0;
  int          n_tests = 0;
  // byte steps wrap inside 15:0; word rows keep the bit 0 left by the last row on that pointer
  row_s rows [8] = '{
    '{5'h00, 2'h0, 2'h1, 1'b0, 16'h0005, 8'h00, 17'h00006, 16'h0006},
    '{5'h00, 2'h0, 2'h1, 1'b1, 16'h0005, 8'h00, 17'h00005, 16'h0006},
    '{5'h00, 2'h1, 2'h2, 1'b0, 16'h0000, 8'h00, 17'h0FFFF, 16'hFFFF},
    '{5'h00, 2'h0, 2'h1, 1'b0, 16'hFFFF, 8'h00, 17'h00000, 16'h0000},
    '{5'h04, 2'h0, 2'h2, 1'b1, 16'h2345, 8'h00, 17'h0468A, 16'h2344},
    '{5'h00, 2'h2, 2'h1, 1'b0, 16'h0100, 8'h10, 17'h00111, 16'h0011},
    '{5'h10, 2'h2, 2'h2, 1'b1, 16'h0100, 8'h04, 17'h00208, 16'h0003},
    '{5'h08, 2'h1, 2'h1, 1'b0, 16'h7FFF, 8'h00, 17'h10000, 16'h8000}};
  logic [7:0]  sel_a [6] = '{8'hE4, 8'hE4, 8'hE4, 8'hF7, 8'hE7, 8'hF3};
  logic [1:0]  sel_x [6] = '{2'h2, 2'h1, 2'h0, 2'h1, 2'h2, 2'h0};

  always #10 ref_clk = ~ref_clk;

  data_pointer_address_unit DUT (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_ptr(mem_ptr), .mem_op(mem_op), .code_fetch_hit(code_fetch_hit), .dmem_addr(dmem_addr),
    .dmem_word(dmem_word), .dmem_rd(dmem_rd), .dmem_wr(dmem_wr),
    .source_pointer_select(source_pointer_select), .source_valid(source_valid));
  dptr_core_model core (
    .ref_clk(ref_clk), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_ptr(mem_ptr), .mem_op(mem_op),
    .code_fetch_hit(code_fetch_hit));

  // ------------------------------------------------------------
  // bus cycles, comparisons and verdict
  // ------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    v = reg_rdata;
    h = reg_hit;
  endtask
  task automatic chk_data(input string what, input logic [16:0] exp, input logic [16:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_flag(input string what, input logic exp, input logic got);
    chk_data(what, {16'h0000, exp}, {16'h0000, got});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [7:0] padr(input logic [1:0] p);
    return (p == 2'h0) ? 8'hF3 : (p == 2'h1) ? 8'hF7 : 8'hE3;
  endfunction

  // the whole run needs well under a thousand cycles
  initial begin
    #40000;
    n_mismatch++;
    give_verdict();
  end

  // ------------------------------------------------------------
  // table of accesses, then the awkward cases
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      wr_reg(8'hE4, {11'h000, rows[i].ctrl});
      wr_reg(rows[i].ptr == 2'h2 ? 8'hE7 : padr(rows[i].ptr), rows[i].pre);
      if (rows[i].ptr == 2'h2) wr_reg(8'hE3, {8'h00, rows[i].ofs});
      core.access(rows[i].rd, rows[i].ptr, rows[i].op);
      w = rows[i].ctrl[2 + rows[i].ptr];
      chk_flag("dmem_word", w, dmem_word);
      chk_data("dmem_addr", rows[i].addr, w ? {dmem_addr[16:1], 1'b0} : {1'b0, dmem_addr[15:0]});
      chk_flag("dmem strobe", 1'b1, rows[i].rd ? dmem_rd : dmem_wr);
      rd_reg(padr(rows[i].ptr));
      chk_data("pointer", {1'b0, rows[i].back}, {1'b0, v});
    end
    rd_reg(8'hE7);
    chk_data("frame base", 17'h00200, {1'b0, v});
    wr_reg(8'hE4, 16'h0000);
    wr_reg(8'hF3, 16'h2345);
    wr_reg(8'hE4, 16'h0004);
    rd_reg(8'hF3);
    chk_data("word view", 17'h011A2, {1'b0, v});
    wr_reg(8'hF3, 16'h2345);
    wr_reg(8'hE4, 16'h0000);
    rd_reg(8'hF3);
    chk_data("byte view", 17'h0468B, {1'b0, v});
    for (int k = 0; k < 6; k++) begin
      wr_reg(sel_a[k], {14'h0000, sel_x[k]});
      @(posedge ref_clk);
      #1;
      chk_data("select", {15'h0000, sel_x[k]}, {15'h0000, source_pointer_select});
    end
    wr_reg(8'h67, 16'hAAAA);
    wr_reg(8'hEB, 16'h5555);
    core.access(1'b1, 2'h0, 2'h1);
    rd_reg(8'h67);
    chk_flag("discard hit", 1'b0, h);
    rd_reg(8'hF3);
    chk_data("stepped pointer", 17'h00001, {1'b0, v});
    core.fetch();
    repeat (2) @(posedge ref_clk);
    #1;
    chk_flag("source_valid", 1'b0, source_valid);
    core.access(1'b0, 2'h1, 2'h0);
    repeat (2) @(posedge ref_clk);
    #1;
    chk_flag("source_valid", 1'b1, source_valid);
    chk_data("select", 17'h00001, {15'h0000, source_pointer_select});
    // select code 11 reads through the frame pointer whatever the decoder names
    wr_reg(8'hE4, 16'h0003);
    core.access(1'b1, 2'h0, 2'h0);
    chk_data("upper select read", 17'h00009, {1'b0, dmem_addr[15:0]});
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    chk_data("select", 17'h00000, {15'h0000, source_pointer_select});
    rd_reg(8'hE4);
    chk_data("control", 17'h00000, {1'b0, v});
    rd_reg(8'hF7);
    chk_data("second pointer", 17'h00000, {1'b0, v});
    give_verdict();
  end
endmodule
